// [design/btx_core.sv]
// Purpose: execution datapath for store character, load address, translate
//          and translate-and-test
// Assumes: storage answers each read with one mem_rvalid pulse, same clock
// Notes:   registers reached over a plain address/strobe port
//
// Operation
// - store character writes only register low byte
// - load address zeroes bits 24-31, address 0-23
// - load address performs no address checks
// - address sum is 24 bits, carry dropped
// - register zero field contributes nothing
// - translate bytes left to right via table
// - first table doubleword before execution is discarded
// - save byte, word, base; add byte to base
// - counters set from table and destination addresses
// - table inside destination word uses local copy
// - route byte, mark, step counters, decrement length
// - loop, store on length end or byte seven
// - condition code zero, one or two
// - all zero leaves registers one, two alone
// - argument address into register one low 24
// - function byte into register two low 8
// - first byte routed, destination counter set from address bits 0-2
// - operand counter from table address, request table byte
// - next address step increments destination counter
// - table word arrives, base restored by subtract
// - nonzero table byte exits to register store
// - code derived from nonzero and pending flags
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module btx_core
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_be,
  output logic      [63:0] mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [63:0] mem_rdata,
  output logic             busy
);
  import btx_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_LA     = 4'b0001,
    S_STC    = 4'b0010,
    S_TDISC  = 4'b0011,
    S_DFETCH = 4'b0100,
    S_DWAIT  = 4'b0101,
    S_TADD   = 4'b0110,
    S_TREQ   = 4'b0111,
    S_TWAIT  = 4'b1000,
    S_TAPPLY = 4'b1001,
    S_TTEST  = 4'b1010,
    S_STORE  = 4'b1011,
    S_MARK   = 4'b1100,
    S_DONE   = 4'b1101
  } btx_state_t;

  btx_state_t  state_reg;
  btx_state_t  state_next;
  btx_op_t     op_reg;
  logic [31:0] gpr_reg [16];
  logic [31:0] instr_reg;
  logic [23:0] dest_cfg_reg;
  logic [7:0]  len_cfg_reg;
  logic [23:0] table_address_reg;
  logic [23:0] table_base_reg;
  logic [23:0] dest_addr_reg;
  logic [23:0] word_addr_reg;
  logic [7:0]  length_count;
  logic [63:0] dest_word_reg;
  logic [63:0] saved_word_reg;
  logic [63:0] operand_word_reg;
  logic [2:0]  dest_byte_counter;
  logic [2:0]  operand_byte_counter;
  logic [7:0]  current_argument_byte;
  logic [7:0]  serial_adder_latch;
  logic [7:0]  mark_reg;
  logic        tbl_pending_reg;
  logic        nonzero_reg;
  logic        end_after_store_reg;
  logic [1:0]  condition_code;
  logic [3:0]  target_reg_field;
  logic [3:0]  index_reg_field;
  logic [3:0]  base_reg_field;
  logic [11:0] displacement_field;
  logic [3:0]  eff_index;
  logic [23:0] eff_addr;
  logic [7:0]  dest_byte;
  logic [7:0]  table_byte;
  logic        table_zero;
  logic        start_req;

  assign target_reg_field   = instr_reg[INSTR_R1_LSB +: 4];
  assign index_reg_field    = instr_reg[INSTR_X2_LSB +: 4];
  assign base_reg_field     = instr_reg[INSTR_B2_LSB +: 4];
  assign displacement_field = instr_reg[INSTR_D2_LSB +: 12];
  // table base of the storage-to-storage ops ignores the index field
  // the start write carries the new op, op_reg only follows it
  assign eff_index = (start_req ? reg_wdata[CTRL_OP_LSB + 1] : op_reg[1])
                     ? 4'h0 : index_reg_field;
  assign start_req = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT] && !busy;

  ////////////////////////////////////////////////////////////////////////////////
  // address arithmetic and serial adder paths

  btx_addr_gen u_addr
  (
    .index_reg_field    (eff_index),
    .base_reg_field     (base_reg_field),
    .displacement_field (displacement_field),
    .index_val          (gpr_reg[eff_index]),
    .base_val           (gpr_reg[base_reg_field]),
    .addr_out           (eff_addr)
  );

  btx_byte_sel u_dest_sel
  (
    .word_in   (dest_word_reg),
    .byte_idx  (dest_byte_counter),
    .byte_out  (dest_byte),
    .byte_zero ()
  );

  btx_byte_sel u_tbl_sel
  (
    .word_in   (operand_word_reg),
    .byte_idx  (operand_byte_counter),
    .byte_out  (table_byte),
    .byte_zero (table_zero)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_reg    <= RST_WORD;
      dest_cfg_reg <= RST_WORD[23:0];
      len_cfg_reg  <= RST_WORD[7:0];
      op_reg       <= OP_STORE_CHAR;
    end
    else if (reg_wr && !busy)
    begin
      case (reg_addr)
        REG_CTRL:  op_reg       <= btx_op_t'(reg_wdata[CTRL_OP_LSB +: 2]);
        REG_INSTR: instr_reg    <= reg_wdata;
        REG_DEST:  dest_cfg_reg <= reg_wdata[23:0];
        REG_LEN:   len_cfg_reg  <= reg_wdata[7:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= RST_WORD;
    end
    else if (reg_rd)
    begin
      if (reg_addr <= REG_GPR_LAST && reg_addr[1:0] == 2'b00)
      begin
        reg_rdata <= gpr_reg[reg_addr[5:2]];
      end
      else
      begin
        case (reg_addr)
          REG_CTRL:   reg_rdata <= {30'h0000_0000, op_reg};
          REG_INSTR:  reg_rdata <= instr_reg;
          REG_DEST:   reg_rdata <= {8'h00, dest_cfg_reg};
          REG_LEN:    reg_rdata <= {24'h00_0000, len_cfg_reg};
          REG_STATUS: reg_rdata <= {16'h0000, mark_reg, nonzero_reg, tbl_pending_reg,
                                    condition_code, 3'b000, busy};
          default:    reg_rdata <= RST_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // general registers

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
      begin
        gpr_reg[i] <= RST_WORD;
      end
    end
    else if (state_reg == S_LA)
    begin
      gpr_reg[target_reg_field] <= {8'h00, eff_addr};
    end
    else if (state_reg == S_MARK)
    begin
      gpr_reg[GPR_ADDR_ARG]  <= {gpr_reg[GPR_ADDR_ARG][31:24], dest_addr_reg};
      gpr_reg[GPR_FUNC_BYTE] <= {gpr_reg[GPR_FUNC_BYTE][31:8], serial_adder_latch};
    end
    else if (reg_wr && !busy && reg_addr <= REG_GPR_LAST && reg_addr[1:0] == 2'b00)
    begin
      gpr_reg[reg_addr[5:2]] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (start_req)
        begin
          case (btx_op_t'(reg_wdata[CTRL_OP_LSB +: 2]))
            OP_LOAD_ADDR:  state_next = S_LA;
            OP_STORE_CHAR: state_next = S_STC;
            default:       state_next = S_TDISC;
          endcase
        end
      end
      S_LA:     state_next = S_DONE;
      S_STC:    state_next = S_DONE;
      S_TDISC:  state_next = mem_rvalid ? S_DFETCH : S_TDISC;
      S_DFETCH: state_next = S_DWAIT;
      S_DWAIT:  state_next = mem_rvalid ? S_TADD : S_DWAIT;
      S_TADD:   state_next = S_TREQ;
      S_TREQ:   state_next = S_TWAIT;
      S_TWAIT:
      begin
        if (mem_rvalid)
        begin
          state_next = (op_reg == OP_TRANSLATE) ? S_TAPPLY : S_TTEST;
        end
      end
      S_TAPPLY:
      begin
        if (length_count == 8'h00 || dest_byte_counter == LAST_BYTE)
        begin
          state_next = S_STORE;
        end
        else
        begin
          state_next = S_TADD;
        end
      end
      S_TTEST:
      begin
        if (!table_zero)
        begin
          state_next = S_MARK;
        end
        else if (length_count == 8'h00)
        begin
          state_next = S_DONE;
        end
        else if (dest_byte_counter == LAST_BYTE)
        begin
          state_next = S_DFETCH;
        end
        else
        begin
          state_next = S_TADD;
        end
      end
      S_STORE:  state_next = end_after_store_reg ? S_DONE : S_DFETCH;
      S_MARK:   state_next = S_DONE;
      S_DONE:   state_next = S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE;
      busy      <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy      <= (state_next != S_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // storage requests

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= RST_WORD[23:0];
      mem_be    <= RST_WORD[7:0];
      mem_wdata <= {RST_WORD, RST_WORD};
    end
    else
    begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
      case (state_reg)
        S_STC:
        begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= eff_addr;
          mem_be    <= byte_lane(eff_addr[2:0]);
          mem_wdata <= {8{gpr_reg[target_reg_field][7:0]}};
        end
        S_IDLE:
        begin
          if (start_req && reg_wdata[CTRL_OP_LSB + 1])
          begin
            mem_req  <= 1'b1;
            mem_addr <= eff_addr;
          end
        end
        S_DFETCH:
        begin
          mem_req  <= 1'b1;
          mem_addr <= dest_addr_reg;
        end
        S_TREQ:
        begin
          mem_req  <= 1'b1;
          mem_addr <= table_address_reg;
        end
        S_STORE:
        begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= word_addr_reg;
          mem_be    <= mark_reg;
          mem_wdata <= dest_word_reg;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // translate datapath

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_address_reg     <= RST_WORD[23:0];
      table_base_reg        <= RST_WORD[23:0];
      dest_addr_reg         <= RST_WORD[23:0];
      word_addr_reg         <= RST_WORD[23:0];
      length_count          <= RST_WORD[7:0];
      dest_word_reg         <= {RST_WORD, RST_WORD};
      saved_word_reg        <= {RST_WORD, RST_WORD};
      operand_word_reg      <= {RST_WORD, RST_WORD};
      dest_byte_counter     <= RST_WORD[2:0];
      operand_byte_counter  <= RST_WORD[2:0];
      current_argument_byte <= RST_WORD[7:0];
      serial_adder_latch    <= RST_WORD[7:0];
      mark_reg              <= RST_WORD[7:0];
      end_after_store_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (start_req)
          begin
            table_address_reg <= eff_addr;
            dest_addr_reg     <= dest_cfg_reg;
            length_count      <= len_cfg_reg;
            mark_reg          <= 8'h00;
          end
        end
        S_DWAIT:
        begin
          if (mem_rvalid)
          begin
            dest_word_reg     <= mem_rdata;
            operand_word_reg  <= mem_rdata;
            word_addr_reg     <= {dest_addr_reg[23:3], 3'b000};
            dest_byte_counter <= dest_addr_reg[2:0];
            mark_reg          <= 8'h00;
          end
        end
        S_TADD:
        begin
          current_argument_byte <= dest_byte;
          saved_word_reg        <= dest_word_reg;
          table_base_reg        <= table_address_reg;
          table_address_reg     <= table_address_reg + {16'h0000, dest_byte};
        end
        S_TREQ:
        begin
          operand_byte_counter <= table_address_reg[2:0];
          dest_word_reg        <= saved_word_reg;
        end
        S_TWAIT:
        begin
          if (mem_rvalid)
          begin
            if (table_address_reg[23:3] == dest_addr_reg[23:3])
            begin
              operand_word_reg <= dest_word_reg;
            end
            else
            begin
              operand_word_reg <= mem_rdata;
            end
            table_address_reg <= table_address_reg - {16'h0000, current_argument_byte};
          end
        end
        S_TAPPLY:
        begin
          dest_word_reg       <= put_byte(dest_word_reg, dest_byte_counter, table_byte);
          mark_reg            <= mark_reg | byte_lane(dest_byte_counter);
          dest_byte_counter   <= dest_byte_counter + 3'h1;
          dest_addr_reg       <= dest_addr_reg + 24'h00_0001;
          length_count        <= length_count - 8'h01;
          end_after_store_reg <= (length_count == 8'h00);
        end
        S_TTEST:
        begin
          serial_adder_latch <= table_byte;
          if (table_zero && length_count != 8'h00)
          begin
            dest_byte_counter <= dest_byte_counter + 3'h1;
            dest_addr_reg     <= dest_addr_reg + 24'h00_0001;
            length_count      <= length_count - 8'h01;
          end
        end
        S_STORE:
        begin
          mark_reg <= 8'h00;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags and condition code

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbl_pending_reg <= 1'b0;
      nonzero_reg     <= 1'b0;
      condition_code  <= CC_ALL_ZERO;
    end
    else
    begin
      if (start_req)
      begin
        tbl_pending_reg <= 1'b0;
        nonzero_reg     <= 1'b0;
      end
      else if (state_reg == S_TTEST)
      begin
        nonzero_reg     <= !table_zero;
        tbl_pending_reg <= (length_count != 8'h00);
      end
      if (state_reg == S_DONE && op_reg == OP_TRANS_TEST)
      begin
        if (!nonzero_reg)
        begin
          condition_code <= CC_ALL_ZERO;
        end
        else
        begin
          condition_code <= tbl_pending_reg ? CC_EARLY_NZ : CC_LAST_NZ;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_la_high_zero: assert property (state_reg == S_LA |=>
    gpr_reg[$past(target_reg_field)][31:24] == 8'h00)
    else $error("load address left high byte nonzero");
  chk_stc_one_lane: assert property (state_reg == S_STC |=>
    mem_we && $onehot(mem_be) && mem_be == byte_lane(mem_addr[2:0]))
    else $error("store character enabled wrong lanes");
  chk_len_step: assert property (state_reg == S_TAPPLY |=>
    length_count == $past(length_count) - 8'h01)
    else $error("length count did not decrement");
  chk_dest_step: assert property (state_reg == S_TAPPLY |=>
    dest_addr_reg == $past(dest_addr_reg) + 24'h00_0001)
    else $error("destination address did not step");
  chk_base_restore: assert property (state_reg == S_TADD ##1 state_reg == S_TREQ
    ##[1:1000] (state_reg == S_TWAIT && mem_rvalid) |=>
    table_address_reg == table_base_reg)
    else $error("table base not restored");
  chk_table_req: assert property (state_reg == S_TREQ |=>
    mem_req && !mem_we && mem_addr == table_base_reg + {16'h0000, current_argument_byte})
    else $error("table request address wrong");
  chk_store_end: assert property (state_reg == S_TAPPLY && length_count == 8'h00 |=>
    state_reg == S_STORE ##1 state_reg == S_DONE)
    else $error("translate did not store and end");
  chk_cc_zero: assert property (state_reg == S_DONE && op_reg == OP_TRANS_TEST
    && !nonzero_reg |=> condition_code == CC_ALL_ZERO)
    else $error("condition code not zero");
  chk_gpr2_byte: assert property (state_reg == S_MARK |=>
    gpr_reg[GPR_FUNC_BYTE][7:0] == $past(serial_adder_latch)
    && gpr_reg[GPR_FUNC_BYTE][31:8] == $past(gpr_reg[GPR_FUNC_BYTE][31:8]))
    else $error("function byte not inserted");
  chk_gpr_keep: assert property (state_reg == S_TTEST && table_zero
    && length_count == 8'h00 |=> $stable(gpr_reg[GPR_ADDR_ARG])
    && $stable(gpr_reg[GPR_FUNC_BYTE]))
    else $error("register one changed on all zero");

  cov_trans: cover property (state_reg == S_TAPPLY ##1 state_reg == S_STORE);
  cov_trt_nz: cover property (state_reg == S_MARK);
  cov_overlap: cover property (state_reg == S_TWAIT && mem_rvalid
    && table_address_reg[23:3] == dest_addr_reg[23:3]);
  cov_la: cover property (state_reg == S_LA);

endmodule

// [design/btx_pkg.sv]
// Purpose: shared constants and helpers for the byte translate execution block
// Assumes: big-endian byte numbering, byte 0 is bits 63:56 of a doubleword
// Notes:   register offsets are byte addresses on the plain register port
package btx_pkg;

  localparam int unsigned ADDR_W = 24;

  // register map
  localparam logic [7:0] REG_GPR_BASE   = 8'h00;
  localparam logic [7:0] REG_GPR_LAST   = 8'h3c;
  localparam logic [7:0] REG_CTRL       = 8'h40;
  localparam logic [7:0] REG_INSTR      = 8'h44;
  localparam logic [7:0] REG_DEST       = 8'h48;
  localparam logic [7:0] REG_LEN        = 8'h4c;
  localparam logic [7:0] REG_STATUS     = 8'h50;

  // field positions
  localparam int unsigned CTRL_OP_LSB    = 0;
  localparam int unsigned CTRL_START_BIT = 4;
  localparam int unsigned INSTR_R1_LSB   = 20;
  localparam int unsigned INSTR_X2_LSB   = 16;
  localparam int unsigned INSTR_B2_LSB   = 12;
  localparam int unsigned INSTR_D2_LSB   = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_CC_LSB    = 4;
  localparam int unsigned STAT_PEND_BIT  = 6;
  localparam int unsigned STAT_NZ_BIT    = 7;
  localparam int unsigned STAT_MARK_LSB  = 8;

  // reset values and counts
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [2:0]  LAST_BYTE     = 3'h7;
  localparam logic [2:0]  TEST_BYTE     = 3'h3;
  localparam logic [3:0]  GPR_ADDR_ARG  = 4'h1;
  localparam logic [3:0]  GPR_FUNC_BYTE = 4'h2;
  localparam logic [1:0]  CC_ALL_ZERO   = 2'h0;
  localparam logic [1:0]  CC_EARLY_NZ   = 2'h1;
  localparam logic [1:0]  CC_LAST_NZ    = 2'h2;

  typedef enum logic [1:0] {
    OP_STORE_CHAR = 2'b00,
    OP_LOAD_ADDR  = 2'b01,
    OP_TRANSLATE  = 2'b10,
    OP_TRANS_TEST = 2'b11
  } btx_op_t;

  // one-hot byte enable for a byte index
  function automatic logic [7:0] byte_lane(input logic [2:0] idx);
    byte_lane = 8'h01 << idx;
  endfunction

  // replace byte idx of a doubleword
  function automatic logic [63:0] put_byte(input logic [63:0] w, input logic [2:0] idx,
                                           input logic [7:0] b);
    logic [63:0] r;
    r = w;
    for (int i = 0; i < 8; i++)
    begin
      if (3'(i) == idx)
      begin
        r[63-8*i -: 8] = b;
      end
    end
    put_byte = r;
  endfunction

endpackage

// [design/btx_addr_gen.sv]
// Purpose: index plus base plus displacement address arithmetic
// Assumes: register zero in the index or base field contributes zero
// Notes:   carries above the 24th bit are dropped
`timescale 1ns/10ps
module btx_addr_gen
(
  input  wire logic [3:0]  index_reg_field,
  input  wire logic [3:0]  base_reg_field,
  input  wire logic [11:0] displacement_field,
  input  wire logic [31:0] index_val,
  input  wire logic [31:0] base_val,
  output logic      [23:0] addr_out
);
  import btx_pkg::*;

  logic [23:0] idx_term;
  logic [23:0] base_term;

  assign idx_term  = (index_reg_field == 4'h0) ? 24'h00_0000 : index_val[23:0];
  assign base_term = (base_reg_field == 4'h0) ? 24'h00_0000 : base_val[23:0];
  assign addr_out  = idx_term + base_term + {12'h000, displacement_field};

endmodule

// [design/btx_byte_sel.sv]
// Purpose: serial adder byte path, selects one byte of a doubleword
// Assumes: byte 0 is the leftmost byte
// Notes:   zero flag feeds the function byte test
`timescale 1ns/10ps
module btx_byte_sel
(
  input  wire logic [63:0] word_in,
  input  wire logic [2:0]  byte_idx,
  output logic      [7:0]  byte_out,
  output logic             byte_zero
);
  import btx_pkg::*;

  logic [5:0] lsb;

  assign lsb       = {3'(LAST_BYTE - byte_idx), 3'b000};
  assign byte_out  = word_in[lsb +: 8];
  assign byte_zero = (byte_out == 8'h00);

endmodule

// [verification/btx_mem_model.sv]
// Purpose: storage model answering doubleword reads and byte writes
// Assumes: one read outstanding, 8 KB held
// Notes:   slow adds wait cycles; data lines toggle outside answers
`timescale 1ns/10ps
module btx_mem_model
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_be,
  input  wire logic [63:0] mem_wdata,
  input  wire logic [2:0]  slow,
  output logic             mem_rvalid,
  output logic      [63:0] mem_rdata
);
  logic [63:0] mem [0:1023];
  logic [3:0]  wait_reg;
  logic [9:0]  idx_reg;
  ////////////////////////////////
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wait_reg   <= 4'h0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 64'h0;
    end
    else
    begin
      mem_rvalid <= wait_reg == 4'h1;
      mem_rdata  <= wait_reg == 4'h1 ? mem[idx_reg] : ~mem_rdata;
      if (wait_reg != 4'h0)
        wait_reg <= wait_reg - 4'h1;
      if (mem_req && !mem_we)
      begin
        idx_reg  <= mem_addr[12:3];
        wait_reg <= {1'b0, slow} + 4'h1;
      end
      if (mem_req && mem_we)
        for (int i = 0; i < 8; i++)
          if (mem_be[i])
            mem[mem_addr[12:3]][63-8*i -: 8] <= mem_wdata[63-8*i -: 8];
    end
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench for the byte translate core
// Assumes: storage model of 8 KB
// Notes:   register reads checked the cycle after the strobe
`timescale 1ns/10ps
module tb_top;
  import btx_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, mem_be, x[16], b0, b1;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, g4, g7, e, q[$], m[$];
  logic        mem_req, mem_we, mem_rvalid, busy, seen;
  logic [23:0] mem_addr;
  logic [63:0] mem_wdata, mem_rdata;
  logic [2:0]  slow = 3'h0;
  integer      seed = 32'hb89907de;
  int          errors = 0, checks = 0, p;
  always #4 clk_sys = ~clk_sys;
  btx_core btx_core_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rvalid,
    .mem_rdata, .busy);
  btx_mem_model btx_mem_model_i (.clk_sys, .rst_n, .mem_req, .mem_we, .mem_addr,
    .mem_be, .mem_wdata, .slow, .mem_rvalid, .mem_rdata);
  ////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
    @(posedge clk_sys);
    q.push_back(d);
    m.push_back(k);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask
  task automatic run(input logic [1:0] op);
    int n;
    slow <= 3'($random(seed));
    wr(REG_CTRL, 32'h10 | 32'(op));
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 3000)
      errors++;
  endtask
  task automatic put(input logic [23:0] a, input logic [7:0] d);
    btx_mem_model_i.mem[a[12:3]][63-8*a[2:0] -: 8] = d;
  endtask
  function automatic logic [7:0] get(input logic [23:0] a);
    return btx_mem_model_i.mem[a[12:3]][63-8*a[2:0] -: 8];
  endfunction
  task automatic cm(input logic [23:0] a, input logic [7:0] d);
    checks++;
    if (get(a) !== d)
    begin
      errors++;
      $display("ERROR mem %h expected %h seen %h", a, d, get(a));
    end
  endtask
  task automatic cr(input logic [31:0] d, input logic [31:0] k);
    checks++;
    if ((reg_rdata & k) !== (d & k))
    begin
      errors++;
      $display("ERROR reg_rdata expected %h seen %h", d & k, reg_rdata & k);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////
  always @(posedge clk_sys)
  begin
    seen <= reg_rd;
    if (seen === 1'b1)
      cr(q.pop_front(), m.pop_front());
  end
  initial
  begin
    #400000;
    errors++;
    complete_run();
  end
  initial
  begin
    for (int i = 0; i < 1024; i++)
      btx_mem_model_i.mem[i] = {$random(seed), $random(seed)};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    g4 = $random(seed);
    g7 = $random(seed);
    e = $random(seed);
    wr(8'h00, 32'hdead_beef);
    wr(8'h10, g4);
    wr(8'h14, 32'hff00_0300);
    wr(8'h18, 32'h0012_3456);
    wr(8'h1c, g7);
    wr(REG_INSTR, {8'h0, 12'h345, e[11:0]});
    run(OP_LOAD_ADDR);
    rd(8'h0c, {8'h0, g4[23:0] + 24'h300 + 24'(e[11:0])}, '1);
    for (int k = 1; k < 3; k++)
    begin
      wr(REG_INSTR, {8'h0, 4'h6, k == 1 ? 8'h06 : 8'h60, e[11:0]});
      run(OP_LOAD_ADDR);
      rd(8'h18, {8'h0, 24'h12_3456 + 24'(k) * 24'(e[11:0])}, '1);
    end
    wr(REG_INSTR, {8'h0, 12'h705, e[11:0]});
    b0 = get(24'h301 + 24'(e[11:0]));
    run(OP_STORE_CHAR);
    cm(24'h300 + 24'(e[11:0]), g7[7:0]);
    cm(24'h301 + 24'(e[11:0]), b0);
    wr(REG_INSTR, {8'h0, 12'h005, 12'h100});
    wr(REG_DEST, 32'h105);
    wr(REG_LEN, 32'd11);
    for (int i = 0; i < 12; i++)
      x[i] = get(24'h400 + 24'(get(24'h105 + 24'(i))));
    b0 = get(24'h104);
    b1 = get(24'h111);
    run(OP_TRANSLATE);
    for (int i = 0; i < 12; i++)
      cm(24'h105 + 24'(i), x[i]);
    cm(24'h104, b0);
    cm(24'h111, b1);
    rd(8'hfc, 32'h0, '1);
    for (int k = 0; k < 3; k++)
    begin
      p = k == 0 ? 4 : k == 1 ? 9 : 10;
      for (int i = 0; i < 256; i++)
        put(24'h400 + 24'(i), 8'h00);
      for (int i = 0; i < 10; i++)
        put(24'h200 + 24'(i), 8'h10 + 8'(i));
      if (p < 10)
        put(24'h410 + 24'(p), 8'h5a);
      wr(8'h04, 32'hab00_0000);
      wr(8'h08, 32'h1234_56c3);
      wr(REG_DEST, 32'h200);
      wr(REG_LEN, 32'd9);
      run(OP_TRANS_TEST);
      rd(REG_STATUS, 32'(((k + 1) % 3) << 4), 32'h31);
      rd(8'h04, p < 10 ? 32'hab00_0200 + 32'(p) : 32'hab00_0000, '1);
      rd(8'h08, p < 10 ? 32'h1234_565a : 32'h1234_56c3, '1);
    end
    wr(REG_INSTR, 32'h0000_5200);
    wr(REG_DEST, 32'h500);
    wr(REG_LEN, 32'd7);
    for (int i = 0; i < 8; i++)
    begin
      x[i] = 8'((i * 5) % 8);
      put(24'h500 + 24'(i), x[i]);
    end
    for (int i = 0; i < 8; i++)
      x[i] = x[x[i][2:0]];
    run(OP_TRANSLATE);
    for (int i = 0; i < 8; i++)
      cm(24'h500 + 24'(i), x[i]);
    repeat (3) @(posedge clk_sys);
    complete_run();
  end
endmodule
